/* sbcsf_pkg.sv */
`default_nettype none
package sbcsf_pkg;
  localparam logic [6:0] ADDR_SUPPLY = 7'h41;
  localparam logic [6:0] ADDR_THERMAL = 7'h42;
  localparam logic [6:0] ADDR_DEVINFO = 7'h43;
  localparam logic [6:0] ADDR_BUSFIRST = 7'h44;
  localparam int CMD_BIT = 7;
  localparam int FRAME_BITS = 16;
  localparam logic [7:0] SUPPLY_RESET = 8'h00;
  localparam logic [7:0] SUPPLY_RSVD_MASK = 8'h02;
  localparam logic [7:0] THERMAL_MASK = 8'h07;
  localparam logic [7:0] THERMAL_RESET = 8'h00;
  localparam logic [7:0] DEVINFO_RESET = 8'h00;
  localparam logic [7:0] BUSFIRST_MASK = 8'h67;
  localparam logic [7:0] BUSFIRST_RESET = 8'h00;
  localparam logic [1:0] PREV_FAILURE = 2'h1;
  localparam logic [1:0] PREV_SLEEP = 2'h2;
  localparam logic [1:0] WDFAIL_MAX = 2'h2;
  localparam logic [4:0] BITCNT_RESET = 5'h00;

  typedef struct packed {
    logic powerOn;
    logic linSupplyUndervolt;
    logic coreSupplyOvervolt;
    logic secondSupplyOvertemp;
    logic secondSupplyUndervolt;
    logic coreSupplyShort;
    logic coreSupplyUndervolt;
    logic severeThermalShutdown;
    logic firstThermalShutdown;
    logic thermalPrewarning;
    logic resetPinStuckHigh;
    logic safeInputPatternError;
    logic failOutputsActive;
    logic linFailValid;
    logic [1:0] firstLinFailureCode;
    logic canFailValid;
    logic [1:0] canFailureCode;
    logic canSupplyUndervolt;
  } sbcsf_events_t;

  typedef struct packed {
    logic coreSupplyOn;
    logic secondSupplyOn;
    logic linActive;
  } sbcsf_gates_t;

  typedef struct packed {
    logic restartFailure;
    logic restartSleep;
    logic watchdogFail;
    logic watchdogTriggerOk;
  } sbcsf_restart_t;

  typedef struct packed {
    logic [7:0] supply;
    logic [7:0] thermal;
    logic [7:0] devInfo;
    logic [7:0] busFirst;
  } sbcsf_regs_t;
endpackage
`default_nettype wire

/* sbcsf_spi_frame.sv */
`default_nettype none
module sbcsf_spi_frame
  import sbcsf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic spiSelect_n,
  input wire logic spiClkRise,
  input wire logic spiClkFall,
  input wire logic spiMosi,
  input wire logic [7:0] readData,
  output logic spiMiso,
  output logic addrValid,
  output logic [7:0] cmdByte,
  output logic frameDone
);
  typedef struct packed {
    logic [4:0] bitCnt;
    logic [15:0] shiftIn;
    logic [7:0] shiftOut;
    logic addrValid;
    logic [7:0] cmdByte;
    logic frameDone;
    logic miso;
  } sbcsf_fr_t;

  sbcsf_fr_t st_ff;
  sbcsf_fr_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.frameDone = 1'b0;
    nxt_st.addrValid = 1'b0;
    if (spiSelect_n)
    begin
      // Exactly 16-bit frames only; shorter or longer ones never raise frameDone
      if (st_ff.bitCnt == 5'(FRAME_BITS))
        nxt_st.frameDone = 1'b1;
      nxt_st.bitCnt = BITCNT_RESET;
    end
    else
    begin
      if (spiClkRise && st_ff.bitCnt != 5'h1F)
      begin
        nxt_st.shiftIn = {st_ff.shiftIn[14:0], spiMosi};
        nxt_st.bitCnt = st_ff.bitCnt + 5'h01;
        if (st_ff.bitCnt == 5'h07)
        begin
          nxt_st.cmdByte = {st_ff.shiftIn[6:0], spiMosi};
          nxt_st.addrValid = 1'b1;
        end
      end
      if (spiClkFall)
      begin
        // Data byte follows the command byte, MSB first
        if (st_ff.bitCnt == 5'h08)
        begin
          nxt_st.miso = readData[7];
          nxt_st.shiftOut = {readData[6:0], 1'b0};
        end
        else
        begin
          nxt_st.miso = st_ff.shiftOut[7];
          nxt_st.shiftOut = {st_ff.shiftOut[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign spiMiso = st_ff.miso;
  assign addrValid = st_ff.addrValid;
  assign cmdByte = st_ff.cmdByte;
  assign frameDone = st_ff.frameDone;
endmodule // sbcsf_spi_frame
`default_nettype wire

/* sbcsf_status_regs.sv */
`default_nettype none
// Functional notes
// - Supply fault register at 0x41: POR, LIN UV, core OV, 2nd OT/UV, short, rsvd, core UV.
// - Supply register bits 6:0 zero after reset; bit 7 reports power-on.
// - Core short and core undervoltage not set while core supply off.
// - Second supply flags not set while second supply off.
// - LIN undervoltage not set while all LIN transceivers wake-capable or off.
// - Reserved bits read zero and ignore clears.
// - Thermal register 0x42, bits 2:0 flags, resets zero, restart keeps them.
// - Severe thermal shutdown sets its flag and forces fail-safe mode.
// - Device info register 0x43 resets zero; restart keeps all bits except 7:6.
// - Bits 7:6 hold previous state: 01 failure, 10 sleep wake, 11 unused.
// - Restart from watchdog, severe thermal, core UV or OV gives code 01.
// - Previous-state field holds until the next restart overwrites it or host clears it.
// - Bit 5 reset pin stuck high, bit 4 fail-safe input pattern error.
// - Bits 3:2 count watchdog failures, saturating at 10.
// - Watchdog counter self-clears on a successful watchdog trigger.
// - Invalid SPI command is not executed and sets bit 1.
// - Invalid-command flag clears only by host clear command.
// - Bit 0 set whenever fail outputs were activated.
// - Bus register 0x44: LIN code 6:5, CAN code 2:1, CAN UV bit 0.
// - Command bit 7 low reads, high clears the byte; data ignored; here the watchdog counter bits 3:2 are kept.
// - Apart from watchdog counter, flags change only by host clear; here the bus codes are also overwritten by any new nonzero code.
// - Bus failure codes: 00 none, 01 thermal, 10 TXD timeout, 11 bus timeout.
module sbcsf_status_regs
  import sbcsf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic softReset,
  input wire logic spiSelect_n,
  input wire logic spiClkRise,
  input wire logic spiClkFall,
  input wire logic spiMosi,
  input wire sbcsf_events_t evt,
  input wire sbcsf_gates_t gates,
  input wire sbcsf_restart_t rst,
  output logic spiMiso,
  output logic failSafeReq,
  output logic invalidCmd,
  output logic [7:0] supplyFlags,
  output logic [7:0] thermalFlags,
  output logic [7:0] deviceInfoFlags,
  output logic [7:0] busFailFlagsFirst
);
  typedef struct packed {
    sbcsf_regs_t regs;
    logic failSafe;
    logic invalid;
    logic [7:0] snap;
    logic clearPend;
    logic [6:0] clearAddr;
  } sbcsf_state_t;

  sbcsf_state_t st_ff;
  sbcsf_state_t nxt_st;
  logic addrValid;
  logic [7:0] cmdByte;
  logic frameDone;
  logic [7:0] readData;

  function automatic logic isMapped(input logic [6:0] a);
    isMapped = (a == ADDR_SUPPLY) || (a == ADDR_THERMAL) ||
               (a == ADDR_DEVINFO) || (a == ADDR_BUSFIRST);
  endfunction

  function automatic logic [7:0] selectReg(input sbcsf_regs_t r, input logic [6:0] a);
    unique case (a)
      ADDR_SUPPLY: selectReg = r.supply;
      ADDR_THERMAL: selectReg = r.thermal;
      ADDR_DEVINFO: selectReg = r.devInfo;
      ADDR_BUSFIRST: selectReg = r.busFirst;
      default: selectReg = 8'h00;
    endcase
  endfunction

  // Snapshot taken at the address byte, so a clear answers with the old flags
  assign readData = st_ff.snap;

  sbcsf_spi_frame u_frame (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .spiSelect_n(spiSelect_n),
    .spiClkRise(spiClkRise),
    .spiClkFall(spiClkFall),
    .spiMosi(spiMosi),
    .readData(readData),
    .spiMiso(spiMiso),
    .addrValid(addrValid),
    .cmdByte(cmdByte),
    .frameDone(frameDone)
  );

  always_comb
  begin
    logic [7:0] clrMask;
    logic [7:0] setSup;
    logic [7:0] setThm;
    logic [7:0] setDev;
    logic [7:0] setBus;
    logic [1:0] wdCnt;
    clrMask = 8'h00;
    setSup = 8'h00;
    setThm = 8'h00;
    setDev = 8'h00;
    setBus = 8'h00;
    wdCnt = st_ff.regs.devInfo[3:2];
    nxt_st = st_ff;
    nxt_st.invalid = 1'b0;

    if (addrValid)
    begin
      nxt_st.snap = selectReg(st_ff.regs, cmdByte[6:0]);
      nxt_st.clearPend = cmdByte[CMD_BIT] && isMapped(cmdByte[6:0]);
      nxt_st.clearAddr = cmdByte[6:0];
      // Every address other than the four mapped registers is flagged as an invalid command
      if (!isMapped(cmdByte[6:0]))
        nxt_st.invalid = 1'b1;
    end

    // Clear acts only once the whole frame arrived, so aborted frames clear nothing
    if (frameDone && st_ff.clearPend)
    begin
      clrMask = 8'hFF;
      nxt_st.clearPend = 1'b0;
    end
    else if (frameDone)
      nxt_st.clearPend = 1'b0;

    setSup[6] = evt.linSupplyUndervolt && gates.linActive;
    setSup[5] = evt.coreSupplyOvervolt;
    setSup[4] = evt.secondSupplyOvertemp && gates.secondSupplyOn;
    setSup[3] = evt.secondSupplyUndervolt && gates.secondSupplyOn;
    setSup[2] = evt.coreSupplyShort && gates.coreSupplyOn;
    setSup[0] = evt.coreSupplyUndervolt && gates.coreSupplyOn;
    setSup[7] = evt.powerOn;
    setThm = {5'h00, evt.severeThermalShutdown, evt.firstThermalShutdown,
              evt.thermalPrewarning};
    setDev[5] = evt.resetPinStuckHigh;
    setDev[4] = evt.safeInputPatternError;
    setDev[1] = nxt_st.invalid;
    setDev[0] = evt.failOutputsActive;
    setBus[0] = evt.canSupplyUndervolt;

    // Set wins over clear on every flag; reserved bits masked off
    if (st_ff.clearAddr == ADDR_SUPPLY)
      nxt_st.regs.supply = (st_ff.regs.supply & ~clrMask) | setSup;
    else
      nxt_st.regs.supply = st_ff.regs.supply | setSup;
    nxt_st.regs.supply = nxt_st.regs.supply & ~SUPPLY_RSVD_MASK;

    if (st_ff.clearAddr == ADDR_THERMAL)
      nxt_st.regs.thermal = ((st_ff.regs.thermal & ~clrMask) | setThm) & THERMAL_MASK;
    else
      nxt_st.regs.thermal = (st_ff.regs.thermal | setThm) & THERMAL_MASK;

    if (st_ff.clearAddr == ADDR_BUSFIRST)
      nxt_st.regs.busFirst = (st_ff.regs.busFirst & ~clrMask) | setBus;
    else
      nxt_st.regs.busFirst = st_ff.regs.busFirst | setBus;
    // A new code overwrites; codes are latched nonzero until cleared
    if (evt.linFailValid && evt.firstLinFailureCode != 2'h0)
      nxt_st.regs.busFirst[6:5] = evt.firstLinFailureCode;
    if (evt.canFailValid && evt.canFailureCode != 2'h0)
      nxt_st.regs.busFirst[2:1] = evt.canFailureCode;
    nxt_st.regs.busFirst = nxt_st.regs.busFirst & BUSFIRST_MASK;

    // Watchdog counter is read-only to the host: a clear leaves it alone
    if (rst.watchdogTriggerOk)
      wdCnt = 2'h0;
    if (rst.watchdogFail && wdCnt != WDFAIL_MAX)
      wdCnt = wdCnt + 2'h1;
    if (st_ff.clearAddr == ADDR_DEVINFO)
      nxt_st.regs.devInfo = (st_ff.regs.devInfo & ~clrMask) | setDev;
    else
      nxt_st.regs.devInfo = st_ff.regs.devInfo | setDev;
    nxt_st.regs.devInfo[3:2] = wdCnt;
    // Restart writes the previous-state field; all other bits persist
    if (rst.restartFailure)
      nxt_st.regs.devInfo[7:6] = PREV_FAILURE;
    else if (rst.restartSleep)
      nxt_st.regs.devInfo[7:6] = PREV_SLEEP;

    if (evt.severeThermalShutdown)
      nxt_st.failSafe = 1'b1;
    else if (rst.restartFailure)
      nxt_st.failSafe = 1'b0;

    if (softReset)
    begin
      // Soft reset zeroes the bank but keeps the power-on indication
      nxt_st.regs.supply = {st_ff.regs.supply[7] | evt.powerOn, 7'h00};
      nxt_st.regs.thermal = THERMAL_RESET;
      nxt_st.regs.devInfo = DEVINFO_RESET;
      nxt_st.regs.busFirst = BUSFIRST_RESET;
      nxt_st.clearPend = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0;
      // Async reset is the power-on reset, so the power-on flag is set
      st_ff.regs.supply <= SUPPLY_RESET | 8'h80;
    end
    else
      st_ff <= nxt_st;
  end

  assign failSafeReq = st_ff.failSafe;
  assign invalidCmd = st_ff.invalid;
  assign supplyFlags = st_ff.regs.supply;
  assign thermalFlags = st_ff.regs.thermal;
  assign deviceInfoFlags = st_ff.regs.devInfo;
  assign busFailFlagsFirst = st_ff.regs.busFirst;
endmodule // sbcsf_status_regs
`default_nettype wire

/* sbcsf_status_regs_monitor.sv */
`default_nettype none
module sbcsf_status_regs_monitor
  import sbcsf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic softReset,
  input wire logic spiSelect_n,
  input wire logic spiClkRise,
  input wire logic spiClkFall,
  input wire logic spiMosi,
  input wire sbcsf_events_t evt,
  input wire sbcsf_gates_t gates,
  input wire sbcsf_restart_t rst,
  input wire logic spiMiso,
  input wire logic failSafeReq,
  input wire logic invalidCmd,
  input wire logic [7:0] supplyFlags,
  input wire logic [7:0] thermalFlags,
  input wire logic [7:0] deviceInfoFlags,
  input wire logic [7:0] busFailFlagsFirst
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence s_severe_set;
    thermalFlags[2] && failSafeReq;
  endsequence
  a_rsvd_read_zero: assert property (
    (supplyFlags & SUPPLY_RSVD_MASK) == 8'h00 && (thermalFlags & ~THERMAL_MASK) == 8'h00
    && (busFailFlagsFirst & ~BUSFIRST_MASK) == 8'h00)
    else $error("reserved bit set");
  a_core_gate_off: assert property (
    $rose(supplyFlags[2]) || $rose(supplyFlags[0]) |-> $past(gates.coreSupplyOn))
    else $error("core flag set while off");
  a_second_gate_off: assert property (
    $rose(supplyFlags[4]) || $rose(supplyFlags[3]) |-> $past(gates.secondSupplyOn))
    else $error("second supply flag set while off");
  a_severe_failsafe: assert property (
    evt.severeThermalShutdown && !softReset && !rst.restartFailure |=> s_severe_set)
    else $error("severe shutdown not flagged");
  a_restart_code: assert property (
    rst.restartFailure && !rst.restartSleep && !softReset |=> deviceInfoFlags[7:6] == PREV_FAILURE)
    else $error("failure restart code missing");
  a_wd_count_step: assert property (
    rst.watchdogFail && !rst.watchdogTriggerOk && !softReset |=>
    deviceInfoFlags[3:2] == (($past(deviceInfoFlags[3:2]) == 2'h0) ? 2'h1 : WDFAIL_MAX))
    else $error("watchdog count wrong");
  a_wd_trigger_clear: assert property (
    rst.watchdogTriggerOk && !rst.watchdogFail |=> deviceInfoFlags[3:2] == 2'h0)
    else $error("watchdog count not cleared");
  a_invalid_flag_set: assert property (
    invalidCmd && !softReset |=> deviceInfoFlags[1])
    else $error("invalid command not flagged");
  a_host_clear_only: assert property (
    $fell(deviceInfoFlags[1]) || $fell(thermalFlags[0]) |->
    $past(softReset) || ($past(spiSelect_n, 2) && !$past(spiSelect_n, 3)))
    else $error("flag dropped without clear");
endmodule // sbcsf_status_regs_monitor
`default_nettype wire

/* sbcsf_spi_host.sv */
`default_nettype none
module sbcsf_spi_host
(
  input wire logic clk_sys,
  input wire logic spiMiso,
  output var logic spiSelect_n,
  output var logic spiClkRise,
  output var logic spiClkFall,
  output var logic spiMosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    spiSelect_n = 1'b1;
    spiClkRise = 1'b0;
    spiClkFall = 1'b0;
    spiMosi = 1'b0;
  end
  // Gaps between clock pulses leave the snapshot time to land before the data byte
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] rd);
    logic [15:0] f;
    f = {cmd, 8'h5A};
    rd = 8'h00;
    @(negedge clk_sys);
    spiSelect_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(negedge clk_sys);
      spiMosi = f[i];
      spiClkRise = 1'b1;
      @(negedge clk_sys);
      spiClkRise = 1'b0;
      if (i < 8)
        rd[i] = spiMiso;
      repeat (2) @(negedge clk_sys);
      spiClkFall = 1'b1;
      @(negedge clk_sys);
      spiClkFall = 1'b0;
    end
    @(negedge clk_sys);
    spiSelect_n = 1'b1;
    // Released line must not look like a held bit
    spiMosi = ~spiMosi;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule // sbcsf_spi_host
`default_nettype wire

/* test_sbcsf_status_regs.sv */
`default_nettype none
module test_sbcsf_status_regs import sbcsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic arst_n, softReset, spiSelect_n, spiClkRise, spiClkFall, spiMosi;
  logic spiMiso, failSafeReq, invalidCmd;
  logic sawInvalid = 1'b0;
  logic [7:0] supplyFlags, thermalFlags, deviceInfoFlags, busFailFlagsFirst, rd;
  sbcsf_events_t evt;
  sbcsf_gates_t gates;
  sbcsf_restart_t rst;
  int errorCnt = 0;
  int nChecks = 0;
  always #4 clk_sys = ~clk_sys;
  sbcsf_status_regs u_sbcsf_status_regs (
    .clk_sys(clk_sys), .arst_n(arst_n), .softReset(softReset), .spiSelect_n(spiSelect_n),
    .spiClkRise(spiClkRise), .spiClkFall(spiClkFall), .spiMosi(spiMosi), .evt(evt),
    .gates(gates), .rst(rst), .spiMiso(spiMiso), .failSafeReq(failSafeReq),
    .invalidCmd(invalidCmd), .supplyFlags(supplyFlags), .thermalFlags(thermalFlags),
    .deviceInfoFlags(deviceInfoFlags), .busFailFlagsFirst(busFailFlagsFirst)
  );
  sbcsf_spi_host u_sbcsf_spi_host (
    .clk_sys(clk_sys), .spiMiso(spiMiso), .spiSelect_n(spiSelect_n),
    .spiClkRise(spiClkRise), .spiClkFall(spiClkFall), .spiMosi(spiMosi)
  );
  always @(posedge clk_sys)
    if (invalidCmd === 1'b1)
      sawInvalid <= 1'b1;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Restart bits, MSB first: failure, sleep, watchdog fail, trigger ok
  task automatic pulse(input sbcsf_events_t e, input sbcsf_restart_t r);
    @(negedge clk_sys);
    evt = e;
    rst = r;
    @(negedge clk_sys);
    evt = '0;
    rst = '0;
    @(negedge clk_sys);
  endtask
  task automatic t_flags();
    check(supplyFlags, 8'h80);
    check(busFailFlagsFirst, 8'h00);
    u_sbcsf_spi_host.xfer({1'b0, ADDR_SUPPLY}, rd);
    check(rd, 8'h80);
    pulse('1, 4'h0);
    check(supplyFlags, 8'hFD);
    check(thermalFlags, 8'h07);
    check({7'h00, failSafeReq}, 8'h01);
    check(deviceInfoFlags, 8'h31);
    check(busFailFlagsFirst, 8'h67);
    u_sbcsf_spi_host.xfer({1'b1, ADDR_SUPPLY}, rd);
    check(rd, 8'hFD);
    check(supplyFlags, 8'h00);
    repeat (20) @(negedge clk_sys);
    check(thermalFlags, 8'h07);
    gates = '0;
    pulse('1, 4'h0);
    check(supplyFlags, 8'hA0);
  endtask
  task automatic t_devinfo();
    logic [7:0] wdExp [3] = '{8'hB5, 8'hB9, 8'hB9};
    pulse('0, 4'h8);
    check(thermalFlags, 8'h07);
    check(deviceInfoFlags, 8'h71);
    pulse('0, 4'h4);
    check(deviceInfoFlags, 8'hB1);
    foreach (wdExp[i])
    begin
      pulse('0, 4'h2);
      check(deviceInfoFlags, wdExp[i]);
    end
    pulse('0, 4'h1);
    check(deviceInfoFlags, 8'hB1);
    u_sbcsf_spi_host.xfer({1'b0, 7'h10}, rd);
    check({7'h00, sawInvalid}, 8'h01);
    pulse('0, 4'h8);
    check(deviceInfoFlags, 8'h73);
    u_sbcsf_spi_host.xfer({1'b1, ADDR_DEVINFO}, rd);
    check(rd, 8'h73);
    check(deviceInfoFlags, 8'h00);
    u_sbcsf_spi_host.xfer({1'b1, ADDR_THERMAL}, rd);
    check(thermalFlags, 8'h00);
  endtask
  task automatic t_codes();
    sbcsf_events_t e;
    u_sbcsf_spi_host.xfer({1'b1, ADDR_BUSFIRST}, rd);
    check(busFailFlagsFirst, 8'h00);
    e = '0;
    e.linFailValid = 1'b1;
    e.canFailValid = 1'b1;
    for (int c = 1; c < 4; c++)
    begin
      e.firstLinFailureCode = c[1:0];
      e.canFailureCode = c[1:0];
      pulse(e, 4'h0);
      check(busFailFlagsFirst, {1'b0, c[1:0], 2'b00, c[1:0], 1'b0});
    end
  endtask
  task automatic t_race();
    fork
      u_sbcsf_spi_host.xfer({1'b1, ADDR_THERMAL}, rd);
      begin
        int n;
        n = 0;
        // Poll on the rising edge, where the host's select is settled
        while (spiSelect_n !== 1'b0 && n < 1000)
        begin
          @(posedge clk_sys);
          n++;
        end
        while (spiSelect_n !== 1'b1 && n < 1000)
        begin
          @(posedge clk_sys);
          n++;
        end
        if (n >= 1000)
          errorCnt++;
        // One-cycle event exactly on the clearing edge, so a lost set shows up
        @(negedge clk_sys);
        evt.thermalPrewarning = 1'b1;
        @(negedge clk_sys);
        evt = '0;
      end
    join
    check(thermalFlags, 8'h01);
  endtask
  task automatic t_soft();
    gates = '1;
    pulse('1, 4'h0);
    softReset = 1'b1;
    @(negedge clk_sys);
    softReset = 1'b0;
    check(supplyFlags, 8'h80);
    check(deviceInfoFlags, 8'h00);
    check(thermalFlags, 8'h00);
    check(busFailFlagsFirst, 8'h00);
  endtask
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    errorCnt++;
    tally_and_finish();
  end
  initial
  begin
    arst_n = 1'b0;
    softReset = 1'b0;
    evt = '0;
    gates = '1;
    rst = '0;
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    t_flags();
    t_devinfo();
    t_codes();
    t_race();
    t_soft();
    tally_and_finish();
  end
endmodule // test_sbcsf_status_regs
bind sbcsf_status_regs sbcsf_status_regs_monitor u_sbcsf_status_regs_monitor (
  .clk_sys(clk_sys), .arst_n(arst_n), .softReset(softReset), .spiSelect_n(spiSelect_n),
  .spiClkRise(spiClkRise), .spiClkFall(spiClkFall), .spiMosi(spiMosi), .evt(evt),
  .gates(gates), .rst(rst), .spiMiso(spiMiso), .failSafeReq(failSafeReq),
  .invalidCmd(invalidCmd), .supplyFlags(supplyFlags), .thermalFlags(thermalFlags),
  .deviceInfoFlags(deviceInfoFlags), .busFailFlagsFirst(busFailFlagsFirst)
);
`default_nettype wire
